// ---- hw/adcs_sequencer.sv ----
// Behaviour
// - Next channel converts while previous is read
// - Hold SCL low at ACK until done
// - Release SCL when conversion done
// - Stop or NACK aborts command conversions
// - Upper pointer bits select inputs one..four
// - Zero select bits read conversion result
// - Cycle register 8 bits, three used
// - Nonzero cycle field triggers periodic conversions
// - Power down after each automatic conversion
// - Cycle mode converts channel-enabled inputs only
// - Cycle mode ascends, one per interval
// - Wrap to lowest, loop until cleared
// - Power-up at fifth falling edge
// - Wake-up plus conversion about three microseconds
// - Command sequence starts lowest, goes upward
`default_nettype none
module adcs_sequencer #(
  parameter logic [6:0] DEV_ADDR = 7'h22, // Arbitrary bus address
  parameter int UNIT_CYCLES = adcs_pkg::CYC_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial bus pins, open drain
  input wire logic scl_in,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe,
  // Quantised analog inputs
  input wire logic [3:0][11:0] analog_sample,
  // Status
  output logic powered_up
);
  localparam int UW = $clog2(UNIT_CYCLES);
  localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYCLES - 1);

  // Lowest set bit as one-hot
  function automatic logic [3:0] lowest(input logic [3:0] m);
    lowest = m & (~m + 4'h1);
  endfunction
  // One-hot to index
  function automatic logic [1:0] idx(input logic [3:0] oh);
    idx = {oh[3] | oh[2], oh[3] | oh[1]};
  endfunction

  // Pin synchronisers and history
  logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
    end else begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
    end
  end
  wire scl_rise = scl_s_ff && !scl_d_ff;
  wire scl_fall = !scl_s_ff && scl_d_ff;
  wire start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
  wire stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;

  // Slave state
  adcs_pkg::adcs_state_t st_ff;
  logic [3:0] bit_cnt_ff; // Bits in current byte
  logic [7:0] sh_ff; // Shift register
  logic rw_ff; // Read transfer
  logic first_ff; // Next write byte is the pointer
  logic rbyte_ff; // Low byte of result pair is next
  logic nack_ff; // Master refused last byte
  logic [7:0] rd_hold_ff; // Low byte of the pair being read
  logic [3:0] ptr_ff; // Register select bits
  logic [7:0] config_ff; // Channel enable bits in upper nibble
  logic [7:0] cycle_ff; // Automatic interval setting

  // Conversion control state
  logic cmd_act_ff; // Command sequence running
  logic [3:0] pend_ff; // Channels still to convert
  logic res_new_ff; // Result not yet handed out
  logic [1:0] last_ff; // Last channel of the automatic loop
  logic [UW-1:0] unit_ff; // Base unit divider
  logic [6:0] ivl_ff; // Units elapsed in interval
  logic eng_done;
  adcs_pkg::adcs_result_t eng_res;

  // Read data selection
  wire [15:0] res_word = {2'h0, eng_res.chan, eng_res.data};
  wire pair_start = (ptr_ff == adcs_pkg::PTR_RESULT) && !rbyte_ff;
  wire need_wait = pair_start && cmd_act_ff && !res_new_ff;
  wire [7:0] reg_byte = (ptr_ff == adcs_pkg::PTR_CONFIG) ? config_ff :
                        (ptr_ff == adcs_pkg::PTR_CYCLE) ? cycle_ff : 8'h00;
  wire [7:0] rd_byte = (ptr_ff != adcs_pkg::PTR_RESULT) ? reg_byte :
                       pair_start ? res_word[15:8] : rd_hold_ff;
  wire bus_evt = start_det || stop_det;
  wire load_addr = (st_ff == adcs_pkg::ST_ADDR_ACK) && scl_fall && rw_ff && !scl_oe;
  wire load_rel = (st_ff == adcs_pkg::ST_RD_ACK) && scl_oe && !need_wait;
  wire load_ack = (st_ff == adcs_pkg::ST_RD_ACK) && !scl_oe && scl_fall && !nack_ff
                  && !need_wait;
  wire byte_load = !bus_evt && (load_addr || load_rel || load_ack);
  wire take = byte_load && pair_start;
  wire addr_hit = (sh_ff[7:1] == DEV_ADDR);
  wire wr_done = (st_ff == adcs_pkg::ST_WR) && scl_fall && (bit_cnt_ff == adcs_pkg::BYTE_BITS);

  // Command decode and start selection
  wire [3:0] cmd_bits = sh_ff[4:1];
  wire cmd_fire = !bus_evt && (st_ff == adcs_pkg::ST_WR) && first_ff && scl_fall
                  && (bit_cnt_ff == adcs_pkg::CMD_FIRE_BITS) && (cmd_bits != 4'h0);
  wire nack_end = (st_ff == adcs_pkg::ST_RD_ACK) && !scl_oe && scl_fall && nack_ff;
  wire cmd_abort = cmd_act_ff && (stop_det || (nack_end && !start_det));
  wire cmd_next = take && cmd_act_ff && (pend_ff != 4'h0);
  wire [3:0] cmd_oh = cmd_fire ? lowest(cmd_bits) : lowest(pend_ff);

  // Automatic cycle decode
  wire [2:0] cyc_field = cycle_ff[adcs_pkg::CYC_LSB +: adcs_pkg::CYC_W];
  wire [3:0] chen = config_ff[adcs_pkg::CHEN_LSB +: 4];
  wire [6:0] ivl_last = 7'(7'h1 << (cyc_field - 3'h1));
  wire unit_tick = (unit_ff == UNIT_LAST);
  wire ivl_hit = unit_tick && (ivl_ff == ivl_last - 7'h1);
  wire auto_fire = (cyc_field != 3'h0) && ivl_hit && !cmd_act_ff && (chen != 4'h0)
                   && !powered_up && !cmd_fire;
  wire [3:0] up_mask = chen & 4'(4'he << last_ff);
  wire [3:0] auto_oh = (up_mask != 4'h0) ? lowest(up_mask) : lowest(chen);

  wire eng_start = cmd_fire || cmd_next || auto_fire;
  wire [1:0] eng_chan = (cmd_fire || cmd_next) ? idx(cmd_oh) : idx(auto_oh);

  // Conversion timing and power state
  adcs_conv_engine #(
    .CONV_CYCLES(adcs_pkg::CONV_CYCLES)
  ) u_engine (
    .clk(clk),
    .rst(rst),
    .start(eng_start),
    .chan(eng_chan),
    .abort(cmd_abort),
    .sample(analog_sample),
    .busy(powered_up),
    .done(eng_done),
    .result(eng_res)
  );

  // Serial slave: address, pointer, register bytes, reads, stretching
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= adcs_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop_det) begin
      st_ff <= adcs_pkg::ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (start_det) begin
      // Repeated start also lands here
      st_ff <= adcs_pkg::ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      case (st_ff)
        adcs_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == adcs_pkg::BYTE_BITS) begin
            if (addr_hit) begin
              st_ff <= adcs_pkg::ST_ADDR_ACK;
              sda_oe <= 1'b1;
              rw_ff <= sh_ff[0];
              scl_oe <= sh_ff[0] && need_wait;
            end else begin
              st_ff <= adcs_pkg::ST_IDLE;
            end
          end
        end
        adcs_pkg::ST_ADDR_ACK: begin
          if (scl_oe && !need_wait) begin
            scl_oe <= 1'b0;
          end else if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            first_ff <= 1'b1;
            st_ff <= rw_ff ? adcs_pkg::ST_RD : adcs_pkg::ST_WR;
            sh_ff <= rd_byte;
            sda_oe <= rw_ff && !rd_byte[7];
          end
        end
        adcs_pkg::ST_WR: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (wr_done) begin
            st_ff <= adcs_pkg::ST_WR_ACK;
            sda_oe <= 1'b1;
          end
        end
        adcs_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            st_ff <= adcs_pkg::ST_WR;
            sda_oe <= 1'b0;
            bit_cnt_ff <= 4'h0;
            first_ff <= 1'b0;
          end
        end
        adcs_pkg::ST_RD: begin
          if (scl_fall) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == adcs_pkg::LAST_RD_FALL) begin
              st_ff <= adcs_pkg::ST_RD_ACK;
              sda_oe <= 1'b0;
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              sda_oe <= !sh_ff[6];
            end
          end
        end
        adcs_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nack_ff <= sda_s_ff;
          end
          if (byte_load) begin
            scl_oe <= 1'b0;
            st_ff <= adcs_pkg::ST_RD;
            bit_cnt_ff <= 4'h0;
            sh_ff <= rd_byte;
            sda_oe <= !rd_byte[7];
          end else if (nack_end) begin
            st_ff <= adcs_pkg::ST_IDLE;
          end else if (scl_fall && need_wait) begin
            scl_oe <= 1'b1;
          end
        end
        default: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
      endcase
    end
  end

  // Register writes and result pairing
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_ff <= adcs_pkg::PTR_RST;
      config_ff <= adcs_pkg::CONFIG_RST;
      cycle_ff <= adcs_pkg::CYCLE_RST;
      rbyte_ff <= 1'b0;
      rd_hold_ff <= 8'h00;
    end else begin
      if (wr_done && first_ff) begin
        ptr_ff <= sh_ff[3:0];
        rbyte_ff <= 1'b0;
      end else if (wr_done && ptr_ff == adcs_pkg::PTR_CONFIG) begin
        config_ff <= sh_ff;
      end else if (wr_done && ptr_ff == adcs_pkg::PTR_CYCLE) begin
        cycle_ff <= sh_ff;
      end
      if (byte_load && ptr_ff == adcs_pkg::PTR_RESULT) begin
        rbyte_ff <= !rbyte_ff;
      end
      if (take) begin
        rd_hold_ff <= res_word[7:0];
      end
    end
  end

  // Command sequence bookkeeping; a new result beats a hand-out
  always_ff @(posedge clk) begin
    if (rst || cmd_abort) begin
      cmd_act_ff <= 1'b0;
      pend_ff <= 4'h0;
      res_new_ff <= 1'b0;
    end else begin
      if (cmd_fire) begin
        cmd_act_ff <= 1'b1;
        pend_ff <= cmd_bits & ~cmd_oh;
      end else if (cmd_next) begin
        pend_ff <= pend_ff & ~cmd_oh;
      end else if (take && pend_ff == 4'h0) begin
        cmd_act_ff <= 1'b0;
      end
      if (eng_done) begin
        res_new_ff <= 1'b1;
      end else if (take || cmd_fire) begin
        res_new_ff <= 1'b0;
      end
    end
  end

  // Interval timer for automatic cycling
  always_ff @(posedge clk) begin
    if (rst || cyc_field == 3'h0) begin
      unit_ff <= '0;
      ivl_ff <= 7'h0;
      last_ff <= 2'h3; // Next loop starts from the lowest channel
    end else begin
      unit_ff <= unit_tick ? '0 : unit_ff + 1'b1;
      if (ivl_hit) begin
        ivl_ff <= 7'h0;
      end else if (unit_tick) begin
        ivl_ff <= ivl_ff + 7'h1;
      end
      if (auto_fire) begin
        last_ff <= idx(auto_oh);
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/adcs_pkg.sv ----
`default_nettype none
package adcs_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 3000;
  // Wake-up plus conversion, rounded up to whole cycles
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Base unit of the automatic interval
  localparam int CYC_UNIT_NS = 1000000;
  localparam int CYC_UNIT_CYCLES = CYC_UNIT_NS / CLK_PERIOD_NS;

  // Register select values of the pointer byte
  localparam logic [3:0] PTR_RESULT = 4'h0;
  localparam logic [3:0] PTR_CONFIG = 4'h2;
  localparam logic [3:0] PTR_CYCLE = 4'h3;

  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] CYCLE_RST = 8'h00;
  localparam logic [3:0] PTR_RST = 4'h0;

  // Field positions
  localparam int CMD_LSB = 4;
  localparam int CHEN_LSB = 4;
  localparam int CYC_LSB = 0;
  localparam int CYC_W = 3;
  // Bits of the pointer byte seen at the fifth falling edge
  localparam logic [3:0] CMD_FIRE_BITS = 4'h5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_RD_FALL = 4'h7;

  // Result of one conversion
  typedef struct packed {
    logic [1:0] chan;
    logic [11:0] data;
  } adcs_result_t;

  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110
  } adcs_state_t;
endpackage
`default_nettype wire

// ---- hw/adcs_conv_engine.sv ----
`default_nettype none
module adcs_conv_engine #(
  parameter int CONV_CYCLES = adcs_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [1:0] chan,
  input wire logic abort,
  // Quantised samples of the four inputs
  input wire logic [3:0][11:0] sample,
  // Status and result
  output logic busy,
  output logic done,
  output adcs_pkg::adcs_result_t result
);
  // Counter wide enough for the whole conversion
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

  logic [CW-1:0] cnt_ff; // Cycles spent powered up
  logic [1:0] chan_ff; // Channel under conversion
  wire finish = busy && (cnt_ff == LAST);

  // Powered only while converting; a restart simply reloads
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      busy <= 1'b0;
      cnt_ff <= '0;
    end else if (start) begin
      busy <= 1'b1;
      cnt_ff <= '0;
      chan_ff <= chan;
    end else if (finish) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Result taken at the end of the conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= finish && !start && !abort;
      if (finish && !start && !abort) begin
        result <= '{chan: chan_ff, data: sample[chan_ff]};
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/adcs_assertions.sv ----
`default_nettype none
module adcs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched outputs
  input wire logic scl_oe,
  input wire logic powered_up
);
  timeunit 1ns;
  timeprecision 1ns;
  // Length of the running conversion
  logic [9:0] up_cnt_ff;
  logic [9:0] nxt_up_cnt;
  assign nxt_up_cnt = powered_up ? up_cnt_ff + 10'h001 : 10'h000;
  always_ff @(posedge clk) begin
    up_cnt_ff <= rst ? 10'h000 : nxt_up_cnt;
  end
  property p_conv_len;
    @(posedge clk) disable iff (rst) up_cnt_ff <= 10'h178;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too long");
  property p_min_len;
    @(posedge clk) disable iff (rst) $rose(powered_up) |-> powered_up[*8];
  endproperty
  a_min_len: assert property (p_min_len) else $error("conversion too short");
  property p_stretch_cause;
    @(posedge clk) disable iff (rst) $rose(scl_oe) |-> powered_up;
  endproperty
  a_stretch_cause: assert property (p_stretch_cause) else $error("stretch, no conversion");
  // Done comes two cycles before the release, so power drops first, or with it on a stop
  property p_stretch_hold;
    @(posedge clk) disable iff (rst) scl_oe && powered_up |=> scl_oe || !powered_up;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("stretch dropped early");
  property p_stretch_release;
    @(posedge clk) disable iff (rst) scl_oe && !powered_up |-> ##[1:2] !scl_oe;
  endproperty
  a_stretch_release: assert property (p_stretch_release) else $error("clock not released");
  property p_stretch_bound;
    @(posedge clk) disable iff (rst) $rose(scl_oe) |-> ##[1:380] !scl_oe;
  endproperty
  a_stretch_bound: assert property (p_stretch_bound) else $error("stretch too long");
  property p_start_free;
    @(posedge clk) disable iff (rst) $rose(powered_up) |-> !scl_oe;
  endproperty
  a_start_free: assert property (p_start_free) else $error("start while stretching");
  property p_gap;
    @(posedge clk) disable iff (rst) $fell(powered_up) |=> !powered_up;
  endproperty
  a_gap: assert property (p_gap) else $error("no power down");
endmodule
bind adcs_sequencer adcs_assertions u_chk (
  .clk(clk), .rst(rst), .scl_oe(scl_oe), .powered_up(powered_up));
`default_nettype wire

// ---- verif/adcs_i2c_master.sv ----
`default_nettype none
module adcs_i2c_master (
  // Bench clock
  input wire logic clk,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Pulls, high pulls the line low
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  int st_cnt; // Cycles SCL was held by the device
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    st_cnt = 0;
  end
  // Moves only on falling edges
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Release SCL and honour a stretch; bounded so a stuck line ends
  task automatic rise_scl();
    int i;
    scl_low = 1'b0;
    step(1);
    for (i = 0; i < 2000 && scl !== 1'b1; i++) begin
      step(1);
      st_cnt++;
    end
    step(4);
  endtask
  // Start, also repeated start
  task automatic start();
    sda_low = 1'b0;
    step(2);
    rise_scl();
    sda_low = 1'b1;
    step(5);
    scl_low = 1'b1;
    step(3);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    step(2);
    rise_scl();
    sda_low = 1'b0;
    step(5);
  endtask
  // Eight bits then the ninth slot; a one releases the line
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic r9);
    int k;
    for (k = 7; k >= -1; k--) begin
      sda_low = (k < 0) ? !b9 : !d[k];
      step(2);
      rise_scl();
      if (k >= 0) q[k] = sda;
      else r9 = sda;
      scl_low = 1'b1;
      step(3);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/adcs_sequencer_tb.sv ----
`default_nettype none
module adcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 1000; // Short interval unit
  localparam logic [6:0] ADDR = 7'h22; // Arbitrary address
  logic clk;
  logic rst;
  logic scl_oe;
  logic sda_oe;
  logic m_scl;
  logic m_sda;
  logic powered_up;
  logic up_q = 1'b0;
  logic [3:0][11:0] samp;
  logic [7:0] q;
  logic a;
  // Open drain with pull-ups
  wire logic scl_w = !(scl_oe || m_scl);
  wire logic sda_w = !(sda_oe || m_sda);
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int rise_cnt = 0;
  int rise_at = 0;
  adcs_sequencer #(.DEV_ADDR(ADDR), .UNIT_CYCLES(UNIT)) DUT (
    .clk(clk), .rst(rst), .scl_in(scl_w), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_oe(sda_oe), .analog_sample(samp), .powered_up(powered_up));
  adcs_i2c_master M (
    .clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count cycles and conversion starts; cut a hang short
  always @(posedge clk) begin
    cyc++;
    up_q <= powered_up;
    if (powered_up === 1'b1 && up_q === 1'b0) begin
      rise_cnt++;
      rise_at = cyc;
    end
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Byte the device must acknowledge
  task automatic put(input logic [7:0] b);
    M.xfer(b, 1'b1, q, a);
    cmp("ack", 16'h0000, {15'h0000, a});
  endtask
  task automatic adr(input logic rd);
    M.start();
    put({ADDR, rd});
  endtask
  task automatic set_reg(input logic [7:0] p, input logic [7:0] d);
    adr(1'b0);
    put(p);
    put(d);
    M.stop();
  endtask
  task automatic get_reg(input logic [7:0] p, input logic [7:0] exp);
    adr(1'b0);
    put(p);
    adr(1'b1);
    M.xfer(8'hff, 1'b1, q, a);
    M.stop();
    cmp("register", {8'h00, exp}, {8'h00, q});
  endtask
  // One result word, high byte first; last ends with a NACK
  task automatic get_word(input int ch, input logic last);
    logic [7:0] hi;
    M.xfer(8'hff, 1'b0, hi, a);
    M.xfer(8'hff, last, q, a);
    cmp("result", {2'b00, ch[1:0], samp[ch]}, {hi, q});
  endtask
  // Command sequence read straight after the pointer byte
  task automatic cmd_seq(input logic [3:0] sel);
    int n;
    int k;
    n = $countones(sel);
    adr(1'b0);
    put({sel, 4'h0});
    M.st_cnt = 0;
    adr(1'b1);
    cmp("stretched", 16'h0001, {15'h0000, M.st_cnt > 0});
    for (k = 0; k < 4; k++) begin
      if (sel[k]) begin
        n--;
        get_word(k, n == 0);
      end
    end
    M.stop();
  endtask
  task automatic wait_rise();
    int c0;
    int i;
    c0 = rise_cnt;
    for (i = 0; i < 9000 && rise_cnt == c0; i++) M.step(1);
  endtask
  initial begin
    int k;
    int t0;
    rst = 1'b1;
    samp = {12'habc, 12'h789, 12'h456, 12'h123};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    M.step(3);
    get_reg(8'h02, 8'h00);
    get_reg(8'h03, 8'h00);
    get_reg(8'h05, 8'h00);
    cmp("idle", 16'h0000, rise_cnt[15:0]);
    cmd_seq(4'h5);
    cmd_seq(4'he);
    cmd_seq(4'h8);
    // Stop after the pointer byte
    adr(1'b0);
    put(8'h30);
    cmp("powering", 16'h0001, {15'h0000, powered_up});
    M.stop();
    M.step(5);
    cmp("stopped", 16'h0000, {15'h0000, powered_up});
    // NACK while the second input converts
    adr(1'b0);
    put(8'h30);
    adr(1'b1);
    get_word(0, 1'b1);
    cmp("nacked", 16'h0000, {15'h0000, powered_up});
    M.stop();
    // Automatic mode on inputs two and four
    set_reg(8'h02, 8'ha0);
    set_reg(8'h03, 8'h01);
    get_reg(8'h03, 8'h01);
    for (k = 0; k < 3; k++) begin
      wait_rise();
      if (k == 0) t0 = rise_at;
      for (int i = 0; i < 500 && powered_up !== 1'b0; i++) M.step(1);
      adr(1'b0);
      put(8'h00);
      adr(1'b1);
      get_word(k[0] ? 3 : 1, 1'b1);
      M.stop();
    end
    cmp("interval1", 16'(2 * UNIT), 16'(rise_at - t0));
    set_reg(8'h03, 8'h02);
    wait_rise();
    t0 = rise_at;
    wait_rise();
    cmp("interval2", 16'(2 * UNIT), 16'(rise_at - t0));
    set_reg(8'h03, 8'h00);
    t0 = rise_cnt;
    M.step(5000);
    cmp("stopped auto", 16'h0000, 16'(rise_cnt - t0));
    report_and_stop();
  end
endmodule
`default_nettype wire
